// [rtl/rrpc_defs.svh]
// Offsets, field positions, reset values and limits of the request parameter checker
`ifndef RRPC_DEFS_SVH
`define RRPC_DEFS_SVH
`define RRPC_OFS_FUNC        12'h000
`define RRPC_OFS_ADDR        12'h004
`define RRPC_OFS_SIZE        12'h008
`define RRPC_OFS_DEV         12'h00C
`define RRPC_OFS_REQ         12'h010
`define RRPC_OFS_STAT        12'h014
`define RRPC_REQ_GO_BIT      0
`define RRPC_ST_DONE_BIT     0
`define RRPC_ST_ACCEPT_BIT   1
`define RRPC_ST_CLASS_LSB    2
`define RRPC_ST_RESULT_LSB   4
`define RRPC_ST_REASON_LSB   8
`define RRPC_ST_SLAREA_LSB   16
`define RRPC_ST_MSAREA_LSB   20
`define RRPC_RST_FUNC        8'h00
`define RRPC_RST_WORD        32'h00000000
`define RRPC_RST_DEV         4'h0
`define RRPC_DEV_SERIAL      4'h0
`define RRPC_FC_RD_COIL      8'h01
`define RRPC_FC_RD_INRLY     8'h02
`define RRPC_FC_RD_HOLD      8'h03
`define RRPC_FC_RD_INREG     8'h04
`define RRPC_FC_WR_COIL      8'h05
`define RRPC_FC_WR_HOLD      8'h06
`define RRPC_FC_LOOPBACK     8'h08
`define RRPC_FC_WR_COILS     8'h0F
`define RRPC_FC_WR_HOLDS     8'h10
`define RRPC_BIT_ADDR_MAX    32'h0000FFFF
`define RRPC_HOLD_ADDR_MAX   32'h0000FFFE
`define RRPC_INREG_ADDR_MAX  32'h00007FFF
`define RRPC_SIZE_MIN        32'h00000001
`define RRPC_BIT_READ_MAX    32'h000007D0
`define RRPC_WORD_READ_MAX   32'h0000007D
`define RRPC_COILS_WR_MAX    32'h00000320
`define RRPC_HOLDS_WR_MAX    32'h00000064
`define RRPC_RES_NONE        4'h0
`define RRPC_RES_FMT_ERR     4'h4
`define RRPC_RSN_NONE        8'h00
`define RRPC_RSN_ADDR        8'h06
`define RRPC_RSN_SIZE        8'h07
`define RRPC_RSN_FUNC        8'h08
`endif

// [rtl/rrpc_pkg.sv]
// Types shared by the request parameter checker
package rrpc_pkg;
  typedef enum logic [1:0] {
    RRPC_CLASS_NONE = 2'b00,
    RRPC_CLASS_BIT  = 2'b01,
    RRPC_CLASS_WORD = 2'b10
  } rrpc_class_t;
  typedef enum logic [2:0] {
    RRPC_AREA_NONE     = 3'b000,
    RRPC_AREA_GEN_BIT  = 3'b001,
    RRPC_AREA_GEN_WORD = 3'b010,
    RRPC_AREA_IN_BIT   = 3'b011,
    RRPC_AREA_IN_WORD  = 3'b100
  } rrpc_area_t;
endpackage

// [rtl/rrpc_code_decoder.sv]
// Function code classification for the request parameter checker
`timescale 1ns/1ps
`default_nettype none
`include "rrpc_defs.svh"
module rrpc_code_decoder (
  // Request code
  input  wire logic [7:0]          funcCode,
  // Classification
  output var  logic                supported,
  output var  logic                needAddr,
  output var  logic                needSize,
  output var  rrpc_pkg::rrpc_class_t dataClass,
  output var  rrpc_pkg::rrpc_area_t  slaveArea
);
  always_comb begin
    supported = 1'b1;
    needAddr  = 1'b1;
    needSize  = 1'b1;
    dataClass = rrpc_pkg::RRPC_CLASS_NONE;
    slaveArea = rrpc_pkg::RRPC_AREA_NONE;
    case (funcCode)
      `RRPC_FC_RD_COIL, `RRPC_FC_WR_COILS: begin
        dataClass = rrpc_pkg::RRPC_CLASS_BIT;
        slaveArea = rrpc_pkg::RRPC_AREA_GEN_BIT;
      end
      `RRPC_FC_RD_INRLY: begin
        dataClass = rrpc_pkg::RRPC_CLASS_BIT;
        slaveArea = rrpc_pkg::RRPC_AREA_IN_BIT;
      end
      `RRPC_FC_RD_HOLD, `RRPC_FC_WR_HOLDS: begin
        dataClass = rrpc_pkg::RRPC_CLASS_WORD;
        slaveArea = rrpc_pkg::RRPC_AREA_GEN_WORD;
      end
      `RRPC_FC_RD_INREG: begin
        dataClass = rrpc_pkg::RRPC_CLASS_WORD;
        slaveArea = rrpc_pkg::RRPC_AREA_IN_WORD;
      end
      `RRPC_FC_WR_COIL: begin
        dataClass = rrpc_pkg::RRPC_CLASS_BIT;
        slaveArea = rrpc_pkg::RRPC_AREA_GEN_BIT;
        needSize  = 1'b0;
      end
      `RRPC_FC_WR_HOLD: begin
        dataClass = rrpc_pkg::RRPC_CLASS_WORD;
        slaveArea = rrpc_pkg::RRPC_AREA_GEN_WORD;
        needSize  = 1'b0;
      end
      `RRPC_FC_LOOPBACK: begin
        needAddr = 1'b0;
        needSize = 1'b0;
      end
      // Unused, extended and out-of-table codes all refuse
      default: begin
        supported = 1'b0;
        needAddr  = 1'b0;
        needSize  = 1'b0;
      end
    endcase
  end
endmodule // rrpc_code_decoder
`default_nettype wire

// [rtl/rrpc_limit_check.sv]
// Address and size range checks with a single prioritised reason
`timescale 1ns/1ps
`default_nettype none
`include "rrpc_defs.svh"
module rrpc_limit_check #(
  parameter logic [31:0] BIT_READ_MAX      = `RRPC_BIT_READ_MAX,
  parameter logic [31:0] WORD_READ_MAX     = `RRPC_WORD_READ_MAX,
  parameter logic [31:0] COILS_WR_MAX      = `RRPC_COILS_WR_MAX,
  parameter logic [31:0] HOLDS_WR_MAX      = `RRPC_HOLDS_WR_MAX,
  parameter logic [31:0] ALT_BIT_READ_MAX  = `RRPC_BIT_READ_MAX,
  parameter logic [31:0] ALT_WORD_READ_MAX = `RRPC_WORD_READ_MAX,
  parameter logic [31:0] ALT_COILS_WR_MAX  = `RRPC_COILS_WR_MAX,
  parameter logic [31:0] ALT_HOLDS_WR_MAX  = `RRPC_HOLDS_WR_MAX
) (
  // Request
  input  wire logic [7:0]  funcCode,
  input  wire logic [31:0] leadAddr,
  input  wire logic [31:0] xferSize,
  input  wire logic [3:0]  txDevice,
  // From decoder
  input  wire logic        supported,
  input  wire logic        needAddr,
  input  wire logic        needSize,
  // Verdict
  output var  logic        accept,
  output var  logic [3:0]  resultCode,
  output var  logic [7:0]  reasonCode
);
  logic        serialDev;
  logic [31:0] addrMax;
  logic [31:0] sizeMax;
  logic        addrBad;
  logic        sizeBad;
  assign serialDev = (txDevice == `RRPC_DEV_SERIAL);
  always_comb begin
    addrMax = `RRPC_BIT_ADDR_MAX;
    sizeMax = serialDev ? BIT_READ_MAX : ALT_BIT_READ_MAX;
    case (funcCode)
      `RRPC_FC_RD_HOLD, `RRPC_FC_WR_HOLD: begin
        addrMax = `RRPC_HOLD_ADDR_MAX;
        sizeMax = serialDev ? WORD_READ_MAX : ALT_WORD_READ_MAX;
      end
      `RRPC_FC_WR_HOLDS: begin
        addrMax = `RRPC_HOLD_ADDR_MAX;
        sizeMax = serialDev ? HOLDS_WR_MAX : ALT_HOLDS_WR_MAX;
      end
      `RRPC_FC_RD_INREG: begin
        addrMax = `RRPC_INREG_ADDR_MAX;
        sizeMax = serialDev ? WORD_READ_MAX : ALT_WORD_READ_MAX;
      end
      `RRPC_FC_WR_COILS: sizeMax = serialDev ? COILS_WR_MAX : ALT_COILS_WR_MAX;
      default: ;
    endcase
  end
  // Size is an unsigned binary count of bits or words
  assign addrBad = needAddr && (leadAddr > addrMax);
  assign sizeBad = needSize && ((xferSize < `RRPC_SIZE_MIN) || (xferSize > sizeMax));
  always_comb begin
    accept     = 1'b0;
    resultCode = `RRPC_RES_FMT_ERR;
    reasonCode = `RRPC_RSN_NONE;
    if (!supported) begin
      reasonCode = `RRPC_RSN_FUNC;
    end else if (addrBad) begin
      reasonCode = `RRPC_RSN_ADDR;
    end else if (sizeBad) begin
      reasonCode = `RRPC_RSN_SIZE;
    end else begin
      accept     = 1'b1;
      resultCode = `RRPC_RES_NONE;
    end
  end
endmodule // rrpc_limit_check
`default_nettype wire

// [rtl/rrpc_checker.sv]
// APB-reached request parameter checker feeding the serial frame builder
// What this block does
// - Codes 01H-06H, 08H, 0FH and 10H are accepted request types.
// - Extended codes 09H-0BH, 0DH, 0EH and unused 00H, 07H, 0CH are refused.
// - 01H, 02H, 05H, 0FH are bit class; 03H, 04H, 06H, 10H word; loopback none.
// - Slave mapping: coils bit, holding word, relays input bits, inputs input words.
// - Bit codes take a leading bit address from 0 to 65535.
// - Codes 03H, 06H, 10H take a leading word address 0 to 65534.
// - Code 04H takes a leading word address 0 to 32767 only.
// - Address is ignored for unused codes and for loopback.
// - Size counts bits for bit codes and words for word codes.
// - Size limits 2000 for 01H/02H, 125 for 03H/04H, 800 for 0FH, 100 for 10H.
// - Size is ignored for 05H, 06H, loopback and unused codes.
// - Size limits may depend on code and on the selected transmission device.
// - Violations give result 4 with reason 06 address, 07 size, 08 code.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rrpc_defs.svh"
module rrpc_checker #(
  parameter int unsigned    ADDR_W            = 12,
  parameter logic [31:0]    BIT_READ_MAX      = `RRPC_BIT_READ_MAX,
  parameter logic [31:0]    WORD_READ_MAX     = `RRPC_WORD_READ_MAX,
  parameter logic [31:0]    COILS_WR_MAX      = `RRPC_COILS_WR_MAX,
  parameter logic [31:0]    HOLDS_WR_MAX      = `RRPC_HOLDS_WR_MAX,
  parameter logic [31:0]    ALT_BIT_READ_MAX  = `RRPC_BIT_READ_MAX,
  parameter logic [31:0]    ALT_WORD_READ_MAX = `RRPC_WORD_READ_MAX,
  parameter logic [31:0]    ALT_COILS_WR_MAX  = `RRPC_COILS_WR_MAX,
  parameter logic [31:0]    ALT_HOLDS_WR_MAX  = `RRPC_HOLDS_WR_MAX
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Verdict
  output var  logic                  verdictDone,
  output var  logic                  verdictAccept,
  output var  rrpc_pkg::rrpc_class_t verdictClass,
  output var  logic [3:0]            verdictResult,
  output var  logic [7:0]            verdictReason,
  // Frame builder request
  output var  logic                  frameValid,
  output var  logic [7:0]            frameFunc,
  output var  logic [15:0]           frameAddr,
  output var  logic [15:0]           frameSize,
  output var  rrpc_pkg::rrpc_class_t frameClass,
  output var  rrpc_pkg::rrpc_area_t  frameArea
);

  // Byte-lane merge, used by the full-width parameter words
  function automatic logic [31:0] rrpcMerge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Local offset decode
  function automatic logic rrpcHit(
    input logic [ADDR_W-1:0] addr,
    input logic [11:0]       ofs
  );
    return addr == ADDR_W'(ofs);
  endfunction

  // Bus state
  logic                  pready_q;
  logic                  pslverr_q;
  logic [31:0]           prdata_q;
  logic [31:0]           readData;
  logic                  readHit;
  logic                  setupPhase;
  logic                  writeTaken;

  // Parameter registers
  logic [7:0]            funcCode_q;
  logic [31:0]           leadAddr_q;
  logic [31:0]           xferSize_q;
  logic [3:0]            txDevice_q;
  logic [31:0]           funcWord;
  logic [31:0]           devWord;

  // Request strobe
  logic                  reqStrobe_q;

  // Check results
  logic                  supported;
  logic                  needAddr;
  logic                  needSize;
  rrpc_pkg::rrpc_class_t dataClass;
  rrpc_pkg::rrpc_area_t  slaveArea;
  rrpc_pkg::rrpc_area_t  masterArea;
  logic                  accept;
  logic [3:0]            resultCode;
  logic [7:0]            reasonCode;
  logic [15:0]           effAddr;
  logic [15:0]           effSize;

  // Verdict registers
  logic                  verdictDone_q;
  logic                  verdictAccept_q;
  rrpc_pkg::rrpc_class_t verdictClass_q;
  logic [3:0]            verdictResult_q;
  logic [7:0]            verdictReason_q;
  rrpc_pkg::rrpc_area_t  verdictSlArea_q;
  rrpc_pkg::rrpc_area_t  verdictMsArea_q;

  // Frame registers
  logic                  frameValid_q;
  logic [7:0]            frameFunc_q;
  logic [15:0]           frameAddr_q;
  logic [15:0]           frameSize_q;
  rrpc_pkg::rrpc_class_t frameClass_q;
  rrpc_pkg::rrpc_area_t  frameArea_q;

  // APB phases; pready is registered so every access has one wait-free access cycle
  assign setupPhase = psel && !penable && !pready_q;
  assign writeTaken = psel && penable && pready_q && pwrite;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setupPhase;
    end
  end

  // Read mux and address decode, sampled during setup
  always_comb begin
    readData = 32'h00000000;
    readHit  = 1'b1;
    if (rrpcHit(paddr, `RRPC_OFS_FUNC)) begin
      readData = funcWord;
    end else if (rrpcHit(paddr, `RRPC_OFS_ADDR)) begin
      readData = leadAddr_q;
    end else if (rrpcHit(paddr, `RRPC_OFS_SIZE)) begin
      readData = xferSize_q;
    end else if (rrpcHit(paddr, `RRPC_OFS_DEV)) begin
      readData = devWord;
    end else if (rrpcHit(paddr, `RRPC_OFS_REQ)) begin
      readData = 32'h00000000;
    end else if (rrpcHit(paddr, `RRPC_OFS_STAT)) begin
      readData[`RRPC_ST_DONE_BIT]                 = verdictDone_q;
      readData[`RRPC_ST_ACCEPT_BIT]               = verdictAccept_q;
      readData[`RRPC_ST_CLASS_LSB +: 2]           = verdictClass_q;
      readData[`RRPC_ST_RESULT_LSB +: 4]          = verdictResult_q;
      readData[`RRPC_ST_REASON_LSB +: 8]          = verdictReason_q;
      readData[`RRPC_ST_SLAREA_LSB +: 3]          = verdictSlArea_q;
      readData[`RRPC_ST_MSAREA_LSB +: 3]          = verdictMsArea_q;
    end else begin
      readHit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setupPhase) begin
      prdata_q  <= pwrite ? 32'h00000000 : readData;
      pslverr_q <= !readHit;
    end else begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
  end

  // Writable parameter words
  assign funcWord = {24'h000000, funcCode_q};
  assign devWord  = {28'h0000000, txDevice_q};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      funcCode_q <= `RRPC_RST_FUNC;
    end else if (writeTaken && rrpcHit(paddr, `RRPC_OFS_FUNC)) begin
      funcCode_q <= pstrb[0] ? pwdata[7:0] : funcCode_q;
    end
  end

  // Address is kept full width so values past 16 bits are caught, not wrapped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      leadAddr_q <= `RRPC_RST_WORD;
    end else if (writeTaken && rrpcHit(paddr, `RRPC_OFS_ADDR)) begin
      leadAddr_q <= rrpcMerge(leadAddr_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xferSize_q <= `RRPC_RST_WORD;
    end else if (writeTaken && rrpcHit(paddr, `RRPC_OFS_SIZE)) begin
      xferSize_q <= rrpcMerge(xferSize_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txDevice_q <= `RRPC_RST_DEV;
    end else if (writeTaken && rrpcHit(paddr, `RRPC_OFS_DEV)) begin
      txDevice_q <= pstrb[0] ? pwdata[3:0] : txDevice_q;
    end
  end

  // Go bit only counts when its byte lane is written
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reqStrobe_q <= 1'b0;
    end else begin
      reqStrobe_q <= writeTaken && rrpcHit(paddr, `RRPC_OFS_REQ) &&
                     pstrb[0] && pwdata[`RRPC_REQ_GO_BIT];
    end
  end

  // Classification and range checks
  rrpc_code_decoder uDecoder (
    .funcCode  (funcCode_q),
    .supported (supported),
    .needAddr  (needAddr),
    .needSize  (needSize),
    .dataClass (dataClass),
    .slaveArea (slaveArea)
  );

  rrpc_limit_check #(
    .BIT_READ_MAX      (BIT_READ_MAX),
    .WORD_READ_MAX     (WORD_READ_MAX),
    .COILS_WR_MAX      (COILS_WR_MAX),
    .HOLDS_WR_MAX      (HOLDS_WR_MAX),
    .ALT_BIT_READ_MAX  (ALT_BIT_READ_MAX),
    .ALT_WORD_READ_MAX (ALT_WORD_READ_MAX),
    .ALT_COILS_WR_MAX  (ALT_COILS_WR_MAX),
    .ALT_HOLDS_WR_MAX  (ALT_HOLDS_WR_MAX)
  ) uLimits (
    .funcCode   (funcCode_q),
    .leadAddr   (leadAddr_q),
    .xferSize   (xferSize_q),
    .txDevice   (txDevice_q),
    .supported  (supported),
    .needAddr   (needAddr),
    .needSize   (needSize),
    .accept     (accept),
    .resultCode (resultCode),
    .reasonCode (reasonCode)
  );

  // Master side works on general memory except for class none; the class picks bits or words
  always_comb begin
    unique case (dataClass)
      rrpc_pkg::RRPC_CLASS_BIT:  masterArea = rrpc_pkg::RRPC_AREA_GEN_BIT;
      rrpc_pkg::RRPC_CLASS_WORD: masterArea = rrpc_pkg::RRPC_AREA_GEN_WORD;
      default:                   masterArea = rrpc_pkg::RRPC_AREA_NONE;
    endcase
  end

  // Ignored fields go out as zero; single writes move exactly one item
  always_comb begin
    effAddr = needAddr ? leadAddr_q[15:0] : 16'h0000;
    effSize = needSize ? xferSize_q[15:0] : 16'h0000;
    if ((funcCode_q == `RRPC_FC_WR_COIL) || (funcCode_q == `RRPC_FC_WR_HOLD)) begin
      effSize = 16'h0001;
    end
  end

  // Verdict held until the next strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      verdictDone_q   <= 1'b0;
      verdictAccept_q <= 1'b0;
      verdictClass_q  <= rrpc_pkg::RRPC_CLASS_NONE;
      verdictResult_q <= `RRPC_RES_NONE;
      verdictReason_q <= `RRPC_RSN_NONE;
      verdictSlArea_q <= rrpc_pkg::RRPC_AREA_NONE;
      verdictMsArea_q <= rrpc_pkg::RRPC_AREA_NONE;
    end else if (reqStrobe_q) begin
      verdictDone_q   <= 1'b1;
      verdictAccept_q <= accept;
      verdictClass_q  <= dataClass;
      verdictResult_q <= resultCode;
      verdictReason_q <= reasonCode;
      verdictSlArea_q <= slaveArea;
      verdictMsArea_q <= masterArea;
    end
  end

  // Frame request pulses once per accepted strobe; fields hold afterwards
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frameValid_q <= 1'b0;
    end else begin
      frameValid_q <= reqStrobe_q && accept;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frameFunc_q  <= `RRPC_RST_FUNC;
      frameAddr_q  <= 16'h0000;
      frameSize_q  <= 16'h0000;
      frameClass_q <= rrpc_pkg::RRPC_CLASS_NONE;
      frameArea_q  <= rrpc_pkg::RRPC_AREA_NONE;
    end else if (reqStrobe_q && accept) begin
      frameFunc_q  <= funcCode_q;
      frameAddr_q  <= effAddr;
      frameSize_q  <= effSize;
      frameClass_q <= dataClass;
      frameArea_q  <= masterArea;
    end
  end

  // Output drive
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign verdictDone   = verdictDone_q;
  assign verdictAccept = verdictAccept_q;
  assign verdictClass  = verdictClass_q;
  assign verdictResult = verdictResult_q;
  assign verdictReason = verdictReason_q;
  assign frameValid    = frameValid_q;
  assign frameFunc     = frameFunc_q;
  assign frameAddr     = frameAddr_q;
  assign frameSize     = frameSize_q;
  assign frameClass    = frameClass_q;
  assign frameArea     = frameArea_q;

endmodule // rrpc_checker
`default_nettype wire

// [tb/rrpc_checker_sva.sv]
// Port-level assertions for the request parameter checker
`timescale 1ns/1ps
`default_nettype none
module rrpc_checker_sva (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // APB answer
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Verdict and frame request
  input wire logic                  verdictDone,
  input wire logic                  verdictAccept,
  input wire logic [3:0]            verdictResult,
  input wire logic [7:0]            verdictReason,
  input wire logic                  frameValid,
  input wire logic [7:0]            frameFunc,
  input wire logic [15:0]           frameAddr,
  input wire logic [15:0]           frameSize,
  input wire rrpc_pkg::rrpc_class_t frameClass
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  one_access_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  frame_pulse_a: assert property (frameValid |=> !frameValid)
    else $error("frame pulse too long");
  frame_accept_a: assert property (frameValid |-> verdictAccept && verdictResult == 4'h0)
    else $error("frame without accept");
  reject_reason_a: assert property (verdictDone && !verdictAccept |-> verdictResult == 4'h4
    && verdictReason inside {8'h06, 8'h07, 8'h08}) else $error("bad reject report");
  frame_class_a: assert property (frameValid |-> (frameClass == rrpc_pkg::RRPC_CLASS_BIT)
    == (frameFunc inside {8'h01, 8'h02, 8'h05, 8'h0F})) else $error("wrong class");
  inreg_range_a: assert property (frameValid && frameFunc == 8'h04 |-> frameAddr <= 16'h7FFF
    && frameSize inside {[16'h0001:16'h007D]}) else $error("input register range");
  code_ok_a: assert property (frameValid |-> frameFunc inside {[8'h01:8'h06], 8'h08, 8'h0F, 8'h10})
    else $error("unsupported code framed");
  cover property (frameValid);
  cover property (verdictDone && !verdictAccept && verdictReason == 8'h08);
  cover property (pslverr);
endmodule // rrpc_checker_sva
bind rrpc_checker rrpc_checker_sva u_sva (.clk_sys, .rst, .psel, .penable, .pready, .pslverr,
  .verdictDone, .verdictAccept, .verdictResult, .verdictReason, .frameValid, .frameFunc,
  .frameAddr, .frameSize, .frameClass);
`default_nettype wire

// [tb/rrpc_frame_sink.sv]
// Frame builder stand-in that counts and records accepted requests
`timescale 1ns/1ps
`default_nettype none
module rrpc_frame_sink (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Request from the checker
  input  wire logic                 frameValid,
  input  wire logic [7:0]           frameFunc,
  input  wire rrpc_pkg::rrpc_area_t frameArea,
  // Observations
  output var  logic [7:0]           frameCount,
  output var  logic [7:0]           lastFunc,
  output var  logic                 areaBad
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frameCount <= 8'h00;
      lastFunc <= 8'h00;
      areaBad <= 1'b0;
    end else if (frameValid) begin
      frameCount <= frameCount + 8'h01;
      lastFunc <= frameFunc;
      // Sticky, so one stray frame is still seen at the end
      if (!(frameArea inside {rrpc_pkg::RRPC_AREA_NONE, rrpc_pkg::RRPC_AREA_GEN_BIT,
                              rrpc_pkg::RRPC_AREA_GEN_WORD}))
        areaBad <= 1'b1;
    end
  end
endmodule // rrpc_frame_sink
`default_nettype wire

// [tb/tb_remote_request_param_checker.sv]
// Self-checking bench for the request parameter checker
`timescale 1ns/1ps
`default_nettype none
`include "rrpc_defs.svh"
module tb_remote_request_param_checker;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0;
  logic [3:0]            pstrb = 4'hF;
  logic [31:0]           prdata, rd;
  logic                  pready, pslverr, err, verdictDone, verdictAccept, frameValid, areaBad;
  rrpc_pkg::rrpc_class_t verdictClass, frameClass;
  rrpc_pkg::rrpc_area_t  frameArea;
  logic [3:0]            verdictResult;
  logic [7:0]            verdictReason, frameFunc, frameCount, lastFunc;
  logic [15:0]           frameAddr, frameSize;
  logic [7:0]            badCodes [9] = '{8'h00, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
                                          8'h0E, 8'h11};
  int                    badCount = 0;
  int                    comparisons = 0;
  // Alternate device gets a smaller multi-write limit so the selection is visible
  rrpc_checker #(.ALT_HOLDS_WR_MAX(32'h00000032)) uut (.clk_sys, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .verdictDone,
    .verdictAccept, .verdictClass, .verdictResult, .verdictReason, .frameValid, .frameFunc,
    .frameAddr, .frameSize, .frameClass, .frameArea);
  rrpc_frame_sink sink (.clk_sys, .rst, .frameValid, .frameFunc, .frameArea, .frameCount,
    .lastFunc, .areaBad);
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wrapUp;
    $display("comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Holds the request until pready is sampled high at a rising edge; the answer is taken there
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic req(input logic [7:0] f, input logic [31:0] a, input logic [31:0] s,
                     input logic acc, input logic [1:0] cls, input logic [7:0] rsn);
    logic [7:0] cnt;
    logic [3:0] res;
    logic [15:0] fadr, fsz;
    res = acc ? 4'h0 : 4'h4;
    fadr = (f == 8'h08) ? 16'h0 : a[15:0];
    fsz = (f == 8'h08) ? 16'h0 : (f inside {8'h05, 8'h06}) ? 16'h1 : s[15:0];
    apb(`RRPC_OFS_FUNC, 1'b1, {24'h0, f});
    apb(`RRPC_OFS_ADDR, 1'b1, a);
    apb(`RRPC_OFS_SIZE, 1'b1, s);
    cnt = frameCount;
    apb(`RRPC_OFS_REQ, 1'b1, 32'h1);
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk(frameValid, acc, "frame pulse");
    chk({verdictAccept, res, rsn}, {acc, verdictResult, verdictReason}, "verdict");
    chk(verdictClass, cls, "class");
    @(negedge clk_sys);
    chk(frameValid, 1'b0, "pulse end");
    chk(frameCount, cnt + acc, "frames");
    if (acc) chk(lastFunc, f, "framed code");
    if (acc) chk({frameClass, frameAddr, frameSize}, {cls, fadr, fsz}, "frame fields");
    apb(`RRPC_OFS_STAT, 1'b0, 32'h0);
    chk(rd[15:0], {rsn, res, cls, acc, 1'b1}, "status");
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    apb(`RRPC_OFS_STAT, 1'b0, 32'h0);
    chk(rd, 32'h0, "status after reset");
    apb(`RRPC_OFS_FUNC, 1'b1, 32'hFFFFFF11);
    apb(`RRPC_OFS_FUNC, 1'b0, 32'h0);
    chk(rd, 32'h11, "code width");
    apb(12'h020, 1'b0, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped");
    apb(`RRPC_OFS_STAT, 1'b1, 32'hFFFFFFFF);
    chk(err, 1'b0, "status write");
    // Addresses are given unsigned, each upper range end tried both inside and one step past
    req(8'h01, 32'h0000FFFF, 32'h1, 1'b1, 2'b01, 8'h00);
    req(8'h01, 32'h00010000, 32'h1, 1'b0, 2'b01, 8'h06);
    req(8'h02, 32'h3E8, 32'd2000, 1'b1, 2'b01, 8'h00);
    req(8'h01, 32'h0, 32'd2001, 1'b0, 2'b01, 8'h07);
    req(8'h02, 32'h0, 32'h0, 1'b0, 2'b01, 8'h07);
    req(8'h03, 32'h0000FFFE, 32'h1, 1'b1, 2'b10, 8'h00);
    req(8'h03, 32'h0000FFFF, 32'h1, 1'b0, 2'b10, 8'h06);
    req(8'h03, 32'h0, 32'd126, 1'b0, 2'b10, 8'h07);
    req(8'h04, 32'h7FFF, 32'h1, 1'b1, 2'b10, 8'h00);
    req(8'h04, 32'h0, 32'd125, 1'b1, 2'b10, 8'h00);
    req(8'h04, 32'h8000, 32'h0, 1'b0, 2'b10, 8'h06);
    req(8'h05, 32'hFFFF, 32'd9999, 1'b1, 2'b01, 8'h00);
    req(8'h06, 32'hFFFE, 32'h0, 1'b1, 2'b10, 8'h00);
    req(8'h06, 32'hFFFF, 32'h0, 1'b0, 2'b10, 8'h06);
    req(8'h08, 32'h12345678, 32'h0, 1'b1, 2'b00, 8'h00);
    req(8'h0F, 32'h0, 32'd800, 1'b1, 2'b01, 8'h00);
    req(8'h0F, 32'h0, 32'd801, 1'b0, 2'b01, 8'h07);
    req(8'h10, 32'h0, 32'd100, 1'b1, 2'b10, 8'h00);
    req(8'h10, 32'h0, 32'd101, 1'b0, 2'b10, 8'h07);
    foreach (badCodes[i]) req(badCodes[i], 32'h0, 32'h1, 1'b0, 2'b00, 8'h08);
    req(8'h0B, 32'hFFFFFFFF, 32'h0, 1'b0, 2'b00, 8'h08);
    apb(`RRPC_OFS_DEV, 1'b1, 32'h1);
    req(8'h10, 32'h0, 32'd51, 1'b0, 2'b10, 8'h07);
    req(8'h10, 32'h0, 32'd50, 1'b1, 2'b10, 8'h00);
    chk(areaBad, 1'b0, "master area");
    wrapUp;
  end
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(25 * 20000);
    badCount++;
    wrapUp;
  end
endmodule // tb_remote_request_param_checker
`default_nettype wire
